// [hdl/dmc_core_regs.vh]
// Register offsets, field positions, reset values and codes for the data memory core
`ifndef DMC_CORE_REGS_VH
`define DMC_CORE_REGS_VH

// Special function register offsets, same in both banks
`define DMC_OFS_PORT0 8'h00
`define DMC_OFS_PTR0 8'h01
`define DMC_OFS_PORT1 8'h02
`define DMC_OFS_PTR1 8'h03
`define DMC_OFS_BANK 8'h04
`define DMC_OFS_WORK 8'h05
`define DMC_OFS_PCL 8'h06
`define DMC_OFS_LKP 8'h07
`define DMC_OFS_LKH 8'h08
`define DMC_OFS_STAT 8'h0a

// First general purpose location, just past the special area
`define DMC_RAM_BASE 8'h41

// Bank select field
`define DMC_BANK_BIT 0
`define DMC_BANK_RST 1'b0

// Status register bit positions
`define DMC_ST_EXP 5
`define DMC_ST_SLP 4
`define DMC_ST_OV 3
`define DMC_ST_Z 2
`define DMC_ST_HC 1
`define DMC_ST_C 0

// Reset values
`define DMC_FLAG_RST 1'b0
`define DMC_ARITH_RST 4'h0
`define DMC_BYTE_RST 8'h00

// Value seen when an indirect access lands on a port location
`define DMC_NULL_READ 8'h00

// Flag operation codes from the execution core
`define DMC_OP_NONE 3'h0
`define DMC_OP_ADD 3'h1
`define DMC_OP_SUB 3'h2
`define DMC_OP_LOGIC 3'h3
`define DMC_OP_RLC 3'h4
`define DMC_OP_RRC 3'h5

`endif

// [hdl/dmc_core.v]
// Core special function registers, bank logic and general data memory
// What this block does
// - Port locations access the location held in their paired pointer, not themselves.
// - Indirect access landing on a port location reads 00H, writes nothing.
// - Port zero with pointer zero always reaches bank 0.
// - Port one with pointer one reaches the bank given by the bank bit.
// - Direct accesses always reach bank 0; bank 1 data only via port one.
// - Bank select register: bit 0 chooses bank, upper seven bits read zero.
// - Every reset clears bank, except watchdog time-out reset during idle or sleep.
// - Special function registers decode the same in either bank.
// - Program counter low write jumps within page and asks one dummy cycle.
// - Table read completion loads high byte of program word into holder.
// - No register to register move; transfers use working register, ALU results reach it only when alu_to_work_i is set.
// - Status layout: expired 5, sleep 4, overflow 3, zero 2, half 1, carry 0.
// - Software writes to status change only the four arithmetic flags.
// - Expired flag cleared by power-up, watchdog clear, halt; set by time-out.
// - Sleep flag cleared by power-up or watchdog clear; set by halt.
// - Overflow set when carry into msb differs from carry out.
// - Zero flag follows whether the arithmetic or logic result is zero.
// - Half-carry set on low nibble carry, or no nibble borrow on subtract.
// - Carry set on add carry-out or subtract no-borrow; rotates update it.
// - Interrupt entry or call never saves status automatically.
`timescale 1ns/1ps
`include "dmc_core_regs.vh"

module dmc_core #(
    parameter RAM_AW = 6,
    parameter [7:0] LKH_MASK = 8'hff
) (
    input wire clk_i,
    input wire rst_b_i,
    input wire sys_rst_i,
    input wire wdt_sleep_rst_i,
    input wire wdt_timeout_i,
    input wire watchdog_clear_instruction_i,
    input wire halt_i,
    input wire acc_req_i,
    input wire acc_we_i,
    input wire [7:0] acc_addr_i,
    input wire [7:0] acc_wdata_i,
    output reg [7:0] acc_rdata_o,
    output reg acc_rvalid_o,
    output wire per_sel_o,
    output wire per_we_o,
    output wire [8:0] per_addr_o,
    output wire [7:0] per_wdata_o,
    input wire [7:0] per_rdata_i,
    input wire [7:0] pc_low_i,
    output reg pc_jump_o,
    output reg [7:0] pc_jump_low_o,
    input wire tbl_done_i,
    input wire [15:0] tbl_word_i,
    output wire [7:0] lookup_ptr_o,
    input wire alu_valid_i,
    input wire [2:0] alu_op_i,
    input wire [7:0] alu_a_i,
    input wire [7:0] alu_b_i,
    input wire alu_use_c_i,
    input wire alu_to_work_i,
    output reg [7:0] alu_result_o,
    output wire [7:0] working_reg_o,
    output wire [7:0] status_o,
    output wire [7:0] bank_o
);

    localparam RAM_WORDS = 1 << RAM_AW;
    localparam RAM_TOTAL = 2 * RAM_WORDS;

    // True for either port location
    function is_port;
        input [7:0] a;
        begin
            is_port = (a == `DMC_OFS_PORT0) || (a == `DMC_OFS_PORT1);
        end
    endfunction

    // Register state
    reg [7:0] pointer_zero;
    reg [7:0] pointer_one;
    reg bank_select_bit;
    reg [7:0] working_reg;
    reg [7:0] lookup_pointer;
    reg [7:0] lookup_high_byte;
    reg watchdog_expired_flag;
    reg sleep_entered_flag;
    reg signed_excess_flag;
    reg zero_flag;
    reg half_carry_flag;
    reg carry_flag;
    reg [7:0] ram_mem [0:RAM_TOTAL-1];

    // Address resolution
    wire via_port0;
    wire via_port1;
    wire via_port;
    wire [7:0] res_lo;
    wire res_bank;
    wire null_hit;
    wire core_hit;
    wire [7:0] ram_ofs;
    wire ram_hit;
    wire per_hit;
    wire [RAM_AW:0] ram_idx;
    wire wr_go;
    wire rd_go;

    // Direct address names a port: follow its pointer instead
    assign via_port0 = (acc_addr_i == `DMC_OFS_PORT0);
    assign via_port1 = (acc_addr_i == `DMC_OFS_PORT1);
    assign via_port = via_port0 | via_port1;
    assign res_lo = via_port0 ? pointer_zero : (via_port1 ? pointer_one : acc_addr_i);
    // Only port one honours the bank bit; direct and port zero stay in bank 0
    assign res_bank = via_port1 ? bank_select_bit : 1'b0;
    // A pointer that names a port is a dead end: read zero, drop the write
    assign null_hit = via_port & is_port(res_lo);

    // Core registers decode on low address only, so both banks see them
    assign core_hit = ~null_hit & (res_lo <= `DMC_OFS_STAT) & (res_lo != 8'h09);
    // Past the last RAM word: reads give zero, writes are dropped
    assign ram_ofs = res_lo - `DMC_RAM_BASE;
    assign ram_hit = (res_lo >= `DMC_RAM_BASE) && (ram_ofs < RAM_WORDS);
    assign per_hit = ~null_hit & ~core_hit & ~ram_hit & (res_lo < `DMC_RAM_BASE);
    // Physical location is bank joined with the offset past the RAM base
    assign ram_idx = {res_bank, ram_ofs[RAM_AW-1:0]};
    assign wr_go = acc_req_i & acc_we_i;
    assign rd_go = acc_req_i & ~acc_we_i;

    // Peripheral registers are outside; bank travels along for bank-only ones
    // Their read data is sampled on the request edge, so no wait state exists
    assign per_sel_o = acc_req_i & per_hit;
    assign per_we_o = acc_we_i;
    assign per_addr_o = {res_bank, res_lo};
    assign per_wdata_o = acc_wdata_i;

    // Flag arithmetic
    reg alu_cin;
    reg [7:0] alu_bb;
    reg [8:0] sum9;
    reg [4:0] nib5;
    reg [7:0] low8;
    reg [7:0] next_result;
    reg next_c;
    reg next_hc;
    reg next_ov;
    reg [3:0] flag_upd;

    // Subtract adds the inverse, so carry and half carry mean no borrow
    // The seven-bit sum gives the carry into the msb for overflow
    always @* begin
        alu_cin = alu_use_c_i ? carry_flag : (alu_op_i == `DMC_OP_SUB);
        alu_bb = (alu_op_i == `DMC_OP_SUB) ? ~alu_b_i : alu_b_i;
        sum9 = {1'b0, alu_a_i} + {1'b0, alu_bb} + {8'h00, alu_cin};
        nib5 = {1'b0, alu_a_i[3:0]} + {1'b0, alu_bb[3:0]} + {4'h0, alu_cin};
        low8 = {1'b0, alu_a_i[6:0]} + {1'b0, alu_bb[6:0]} + {7'h00, alu_cin};
        next_result = alu_a_i;
        next_c = carry_flag;
        next_hc = half_carry_flag;
        next_ov = signed_excess_flag;
        flag_upd = 4'h0;
        case (alu_op_i)
            `DMC_OP_ADD, `DMC_OP_SUB: begin
                next_result = sum9[7:0];
                next_c = sum9[8];
                next_hc = nib5[4];
                next_ov = low8[7] ^ sum9[8];
                flag_upd = 4'hf;
            end
            `DMC_OP_LOGIC: begin
                next_result = alu_a_i;
                flag_upd = 4'h4;
            end
            `DMC_OP_RLC: begin
                next_result = {alu_a_i[6:0], carry_flag};
                next_c = alu_a_i[7];
                flag_upd = 4'h1;
            end
            `DMC_OP_RRC: begin
                next_result = {carry_flag, alu_a_i[7:1]};
                next_c = alu_a_i[0];
                flag_upd = 4'h1;
            end
            default: begin
                flag_upd = 4'h0;
            end
        endcase
        if (!alu_valid_i) begin
            flag_upd = 4'h0;
        end
    end

    // Write decode for core registers
    wire wr_core;
    assign wr_core = wr_go & core_hit;

    // Pointers, bank, lookup pointer: plain software registers
    // Power-up clears the bank at once; other resets arrive as pulses
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pointer_zero <= `DMC_BYTE_RST;
            pointer_one <= `DMC_BYTE_RST;
            lookup_pointer <= `DMC_BYTE_RST;
            bank_select_bit <= `DMC_BANK_RST;
        end else begin
            if (wr_core && res_lo == `DMC_OFS_PTR0) begin
                pointer_zero <= acc_wdata_i;
            end
            if (wr_core && res_lo == `DMC_OFS_PTR1) begin
                pointer_one <= acc_wdata_i;
            end
            if (wr_core && res_lo == `DMC_OFS_LKP) begin
                lookup_pointer <= acc_wdata_i;
            end
            // Later reset beats a bank write in the same cycle
            if (sys_rst_i) begin
                if (!wdt_sleep_rst_i) begin
                    bank_select_bit <= `DMC_BANK_RST;
                end
            end else if (wr_core && res_lo == `DMC_OFS_BANK) begin
                bank_select_bit <= acc_wdata_i[`DMC_BANK_BIT];
            end
        end
    end

    // Working register: the only staging point between two locations
    // No single access copies one location straight into another
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            working_reg <= `DMC_BYTE_RST;
            alu_result_o <= `DMC_BYTE_RST;
        end else begin
            if (alu_valid_i) begin
                alu_result_o <= next_result;
            end
            // ALU result wins over a bus write aimed at it
            if (alu_valid_i && alu_to_work_i) begin
                working_reg <= next_result;
            end else if (wr_core && res_lo == `DMC_OFS_WORK) begin
                working_reg <= acc_wdata_i;
            end
        end
    end

    // Table read: high byte held here, low byte written by the core
    // Read-only from the bus: a write to this location is ignored
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            lookup_high_byte <= `DMC_BYTE_RST;
        end else if (tbl_done_i) begin
            lookup_high_byte <= tbl_word_i[15:8] & LKH_MASK;
        end
    end

    // Program counter low write becomes a one cycle jump request
    // The core inserts its dummy cycle when it sees the pulse
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pc_jump_o <= 1'b0;
            pc_jump_low_o <= `DMC_BYTE_RST;
        end else begin
            pc_jump_o <= wr_core && (res_lo == `DMC_OFS_PCL);
            if (wr_core && res_lo == `DMC_OFS_PCL) begin
                pc_jump_low_o <= acc_wdata_i;
            end
        end
    end

    // Arithmetic flags: software writes low nibble, ALU overrides per flag
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            signed_excess_flag <= `DMC_FLAG_RST;
            zero_flag <= `DMC_FLAG_RST;
            half_carry_flag <= `DMC_FLAG_RST;
            carry_flag <= `DMC_FLAG_RST;
        end else begin
            if (wr_core && res_lo == `DMC_OFS_STAT) begin
                signed_excess_flag <= acc_wdata_i[`DMC_ST_OV];
                zero_flag <= acc_wdata_i[`DMC_ST_Z];
                half_carry_flag <= acc_wdata_i[`DMC_ST_HC];
                carry_flag <= acc_wdata_i[`DMC_ST_C];
            end
            if (flag_upd[3]) begin
                signed_excess_flag <= next_ov;
            end
            if (flag_upd[2]) begin
                zero_flag <= (next_result == 8'h00);
            end
            if (flag_upd[1]) begin
                half_carry_flag <= next_hc;
            end
            if (flag_upd[0]) begin
                carry_flag <= next_c;
            end
        end
    end

    // System flags: set wins over clear; bus writes never reach them
    // Time-out beats both clears; halt beats the watchdog clear
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            watchdog_expired_flag <= `DMC_FLAG_RST;
            sleep_entered_flag <= `DMC_FLAG_RST;
        end else begin
            if (wdt_timeout_i) begin
                watchdog_expired_flag <= 1'b1;
            end else if (watchdog_clear_instruction_i || halt_i) begin
                watchdog_expired_flag <= 1'b0;
            end
            if (halt_i) begin
                sleep_entered_flag <= 1'b1;
            end else if (watchdog_clear_instruction_i) begin
                sleep_entered_flag <= 1'b0;
            end
        end
    end

    // General data memory, one location per access
    // No reset: contents are undefined after power-up, saves a wide reset tree
    always @(posedge clk_i) begin
        if (wr_go && ram_hit && !null_hit) begin
            ram_mem[ram_idx] <= acc_wdata_i;
        end
    end

    // Status image: top two bits read zero
    assign status_o = {2'b00, watchdog_expired_flag, sleep_entered_flag,
                       signed_excess_flag, zero_flag, half_carry_flag, carry_flag};
    assign bank_o = {7'h00, bank_select_bit};
    assign working_reg_o = working_reg;
    assign lookup_ptr_o = lookup_pointer;

    // Core register read mux
    // Unused slots read zero
    reg [7:0] core_rd;
    always @* begin
        case (res_lo)
            `DMC_OFS_PTR0: core_rd = pointer_zero;
            `DMC_OFS_PTR1: core_rd = pointer_one;
            `DMC_OFS_BANK: core_rd = bank_o;
            `DMC_OFS_WORK: core_rd = working_reg;
            `DMC_OFS_PCL: core_rd = pc_low_i;
            `DMC_OFS_LKP: core_rd = lookup_pointer;
            `DMC_OFS_LKH: core_rd = lookup_high_byte;
            `DMC_OFS_STAT: core_rd = status_o;
            default: core_rd = `DMC_BYTE_RST;
        endcase
    end

    // Read data registered one cycle after the request
    // Status is only a plain location here; nothing copies it on calls
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            acc_rdata_o <= `DMC_BYTE_RST;
            acc_rvalid_o <= 1'b0;
        end else begin
            acc_rvalid_o <= rd_go;
            if (rd_go) begin
                if (null_hit) begin
                    acc_rdata_o <= `DMC_NULL_READ;
                end else if (core_hit) begin
                    acc_rdata_o <= core_rd;
                end else if (ram_hit) begin
                    acc_rdata_o <= ram_mem[ram_idx];
                end else if (per_hit) begin
                    acc_rdata_o <= per_rdata_i;
                end else begin
                    acc_rdata_o <= `DMC_BYTE_RST;
                end
            end
        end
    end

endmodule

// [dv/dmc_per_model.sv]
// Peripheral register responder on the forwarded port
`timescale 1ns/1ps
module dmc_per_model (
    input wire clk_i,
    input wire per_sel_i,
    input wire per_we_i,
    input wire [8:0] per_addr_i,
    input wire [7:0] per_wdata_i,
    output wire [7:0] per_rdata_o
);
    reg [7:0] mem [0:511];
    reg [7:0] last;
    integer i;
    // Known contents so a read shows only what was written
    initial begin
        for (i = 0; i < 512; i = i + 1) begin
            mem[i] = 8'h00;
        end
        last = 8'h00;
    end
    // Write lands on the edge that takes the request
    always @(posedge clk_i) begin
        if (per_sel_i && per_we_i) begin
            mem[per_addr_i] <= per_wdata_i;
        end
        last <= per_rdata_o;
    end
    // Unselected: toggling junk, so a stale sample cannot pass
    assign per_rdata_o = per_sel_i ? mem[per_addr_i] : ~last;
endmodule

// [dv/dmc_core_sva.sv]
// Concurrent checks on the data memory core ports
`timescale 1ns/1ps
module dmc_core_sva (
    input wire clk_i,
    input wire rst_b_i,
    input wire sys_rst_i,
    input wire wdt_sleep_rst_i,
    input wire wdt_timeout_i,
    input wire watchdog_clear_instruction_i,
    input wire halt_i,
    input wire acc_req_i,
    input wire acc_we_i,
    input wire [7:0] acc_addr_i,
    input wire [7:0] acc_wdata_i,
    input wire acc_rvalid_o,
    input wire per_sel_o,
    input wire [8:0] per_addr_o,
    input wire pc_jump_o,
    input wire [7:0] pc_jump_low_o,
    input wire alu_valid_i,
    input wire [2:0] alu_op_i,
    input wire [7:0] alu_a_i,
    input wire [7:0] alu_b_i,
    input wire alu_use_c_i,
    input wire [7:0] status_o,
    input wire [7:0] bank_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    // Plain add carry out, for the carry flag
    wire [8:0] sum9 = {1'b0, alu_a_i} + {1'b0, alu_b_i};
    wire pcl_wr = acc_req_i && acc_we_i && (acc_addr_i == 8'h06);
    // A write through either port may also land on the program counter low
    wire pcl_may = acc_req_i && acc_we_i && (acc_addr_i == 8'h06 || acc_addr_i == 8'h00 || acc_addr_i == 8'h02);
    wire add_nc = alu_valid_i && (alu_op_i == 3'h1) && !alu_use_c_i;
    a_read_answer: assert property (acc_req_i && !acc_we_i |=> acc_rvalid_o)
        else $error("read not answered");
    a_no_spurious_rvalid: assert property (!(acc_req_i && !acc_we_i) |=> !acc_rvalid_o)
        else $error("stray read valid");
    a_bank_upper_zero: assert property (bank_o[7:1] == 7'h00)
        else $error("bank upper bits set");
    a_status_top_zero: assert property (status_o[7:6] == 2'h0)
        else $error("status top bits set");
    a_pcl_jump: assert property (pcl_wr |=> pc_jump_o && pc_jump_low_o == $past(acc_wdata_i))
        else $error("pc low jump wrong");
    a_pcl_jump_only: assert property (!pcl_may |=> !pc_jump_o)
        else $error("jump without pc low write");
    a_direct_bank_zero: assert property (acc_req_i && per_sel_o && acc_addr_i != 8'h00
        && acc_addr_i != 8'h02 |-> !per_addr_o[8])
        else $error("direct access left bank 0");
    a_bank_reset: assert property (sys_rst_i && !wdt_sleep_rst_i |=> bank_o == 8'h00)
        else $error("bank not cleared by reset");
    a_expired_set: assert property (wdt_timeout_i |=> status_o[5])
        else $error("expired flag not set");
    a_expired_hold: assert property (!wdt_timeout_i && !watchdog_clear_instruction_i && !halt_i |=> $stable(status_o[5]))
        else $error("expired flag moved");
    a_sleep_flag: assert property (halt_i && !wdt_timeout_i |=> status_o[5:4] == 2'b01)
        else $error("halt flags wrong");
    a_sleep_hold: assert property (!watchdog_clear_instruction_i && !halt_i |=> $stable(status_o[4]))
        else $error("sleep flag moved");
    a_zero_logic: assert property (alu_valid_i && alu_op_i == 3'h3 |=> status_o[2] == ($past(alu_a_i) == 8'h00))
        else $error("zero flag wrong");
    a_add_carry: assert property (add_nc |=> status_o[0] == $past(sum9[8]))
        else $error("add carry wrong");
    c_read: cover property (acc_req_i && !acc_we_i ##1 acc_rvalid_o);
    c_jump: cover property (pcl_wr ##1 pc_jump_o);
    c_halt: cover property (halt_i ##1 status_o[4]);
    c_bank1: cover property (acc_req_i && per_addr_o[8]);
endmodule
bind dmc_core dmc_core_sva dmc_core_sva_inst (.clk_i(clk_i), .rst_b_i(rst_b_i), .sys_rst_i(sys_rst_i),
    .wdt_sleep_rst_i(wdt_sleep_rst_i), .wdt_timeout_i(wdt_timeout_i), .watchdog_clear_instruction_i(watchdog_clear_instruction_i), .halt_i(halt_i),
    .acc_req_i(acc_req_i), .acc_we_i(acc_we_i), .acc_addr_i(acc_addr_i), .acc_wdata_i(acc_wdata_i),
    .acc_rvalid_o(acc_rvalid_o), .per_sel_o(per_sel_o), .per_addr_o(per_addr_o), .pc_jump_o(pc_jump_o),
    .pc_jump_low_o(pc_jump_low_o), .alu_valid_i(alu_valid_i), .alu_op_i(alu_op_i), .alu_a_i(alu_a_i),
    .alu_b_i(alu_b_i), .alu_use_c_i(alu_use_c_i), .status_o(status_o), .bank_o(bank_o));

// [dv/tb_dmc_core.sv]
// Self-checking bench for the data memory core
`timescale 1ns/1ps
`define CHK(v, e) begin compares = compares + 1; if ((v) !== (e)) begin err_count = err_count + 1; \
    $display("CHECK FAILED %0t got %h want %h", $time, v, e); end end
module tb_dmc_core;
    reg clk_i = 1'b0;
    reg rst_b_i = 1'b0;
    reg acc_req_i = 1'b0;
    reg acc_we_i = 1'b0;
    reg [7:0] acc_addr_i = 8'h00;
    reg [7:0] acc_wdata_i = 8'h00;
    reg [5:0] ev = 6'h00;
    reg alu_valid_i = 1'b0;
    reg [2:0] alu_op_i = 3'h0;
    reg [7:0] alu_a_i = 8'h00;
    reg [7:0] alu_b_i = 8'h00;
    reg alu_use_c_i = 1'b0;
    reg alu_to_work_i = 1'b1;
    wire [7:0] acc_rdata_o, per_wdata_o, per_rdata_i, pc_jump_low_o, lookup_ptr_o;
    wire [7:0] alu_result_o, working_reg_o, status_o, bank_o;
    wire [8:0] per_addr_o;
    wire acc_rvalid_o, per_sel_o, per_we_o, pc_jump_o;
    integer err_count = 0;
    integer compares = 0;
    dmc_core dmc_core_inst (.clk_i(clk_i), .rst_b_i(rst_b_i), .sys_rst_i(ev[4]), .wdt_sleep_rst_i(ev[3]),
        .wdt_timeout_i(ev[2]), .watchdog_clear_instruction_i(ev[1]), .halt_i(ev[0]), .acc_req_i(acc_req_i), .acc_we_i(acc_we_i),
        .acc_addr_i(acc_addr_i), .acc_wdata_i(acc_wdata_i), .acc_rdata_o(acc_rdata_o),
        .acc_rvalid_o(acc_rvalid_o), .per_sel_o(per_sel_o), .per_we_o(per_we_o), .per_addr_o(per_addr_o),
        .per_wdata_o(per_wdata_o), .per_rdata_i(per_rdata_i), .pc_low_i(8'h9e), .pc_jump_o(pc_jump_o),
        .pc_jump_low_o(pc_jump_low_o), .tbl_done_i(ev[5]), .tbl_word_i(16'hb712), .lookup_ptr_o(lookup_ptr_o),
        .alu_valid_i(alu_valid_i), .alu_op_i(alu_op_i), .alu_a_i(alu_a_i), .alu_b_i(alu_b_i),
        .alu_use_c_i(alu_use_c_i), .alu_to_work_i(alu_to_work_i),
        .alu_result_o(alu_result_o), .working_reg_o(working_reg_o),
        .status_o(status_o), .bank_o(bank_o));
    dmc_per_model dmc_per_model_inst (.clk_i(clk_i), .per_sel_i(per_sel_o), .per_we_i(per_we_o),
        .per_addr_i(per_addr_o), .per_wdata_i(per_wdata_o), .per_rdata_o(per_rdata_i));
    // 10 MHz system clock
    always #50 clk_i = ~clk_i;
    task stop_test;
        begin
            if (err_count == 0 && compares > 0) begin
                $display("Result: passed");
            end else begin
                $display("Result: failed");
            end
            $finish;
        end
    endtask
    // One request cycle; strobe dropped on the taking edge
    task wr(input [7:0] a, input [7:0] d);
        begin
            @(posedge clk_i);
            acc_req_i <= 1'b1;
            acc_we_i <= 1'b1;
            acc_addr_i <= a;
            acc_wdata_i <= d;
            @(posedge clk_i);
            acc_req_i <= 1'b0;
        end
    endtask
    // Answer is registered on the taking edge and checked just after it
    task rd(input [7:0] a, input [7:0] e);
        begin
            @(posedge clk_i);
            acc_req_i <= 1'b1;
            acc_we_i <= 1'b0;
            acc_addr_i <= a;
            @(posedge clk_i);
            acc_req_i <= 1'b0;
            #1;
            `CHK(acc_rvalid_o, 1'b1)
            `CHK(acc_rdata_o, e)
        end
    endtask
    // One-cycle event pulse: reset, watchdog, halt, table done
    task pulse(input [5:0] v);
        begin
            @(posedge clk_i);
            ev <= v;
            @(posedge clk_i);
            ev <= 6'h00;
        end
    endtask
    // Flags and working register settle on the taking edge
    task alu(input [2:0] op, input [7:0] a, input [7:0] b, input [7:0] st, input [7:0] w);
        begin
            @(posedge clk_i);
            alu_valid_i <= 1'b1;
            alu_op_i <= op;
            alu_a_i <= a;
            alu_b_i <= b;
            @(posedge clk_i);
            alu_valid_i <= 1'b0;
            #1;
            `CHK(status_o, st)
            `CHK(working_reg_o, w)
        end
    endtask
    // Watchdog: fires after 20000 cycles, far above what the whole sequence needs
    initial begin
        #2000000;
        err_count = err_count + 1;
        stop_test;
    end
    initial begin
        repeat (2) @(posedge clk_i);
        rst_b_i <= 1'b1;
        rd(8'h04, 8'h00);
        rd(8'h0a, 8'h00);
        wr(8'h04, 8'hff);
        rd(8'h04, 8'h01);
        wr(8'h03, 8'h41);
        wr(8'h02, 8'h55);
        wr(8'h04, 8'h00);
        wr(8'h02, 8'haa);
        rd(8'h41, 8'haa);
        wr(8'h04, 8'h01);
        rd(8'h41, 8'haa);
        rd(8'h02, 8'h55);
        wr(8'h01, 8'h41);
        rd(8'h00, 8'haa);
        wr(8'h00, 8'h33);
        rd(8'h41, 8'h33);
        wr(8'h01, 8'h00);
        rd(8'h00, 8'h00);
        wr(8'h00, 8'h77);
        rd(8'h01, 8'h00);
        wr(8'h03, 8'h02);
        rd(8'h02, 8'h00);
        wr(8'h05, 8'h5a);
        rd(8'h03, 8'h02);
        wr(8'h03, 8'h05);
        rd(8'h02, 8'h5a);
        pulse(6'h18);
        rd(8'h04, 8'h01);
        pulse(6'h10);
        rd(8'h04, 8'h00);
        rd(8'h05, 8'h5a);
        wr(8'h06, 8'hc3);
        #1;
        `CHK(pc_jump_o, 1'b1)
        `CHK(pc_jump_low_o, 8'hc3)
        @(posedge clk_i);
        #1;
        `CHK(pc_jump_o, 1'b0)
        rd(8'h06, 8'h9e);
        pulse(6'h20);
        rd(8'h08, 8'hb7);
        wr(8'h08, 8'h00);
        rd(8'h08, 8'hb7);
        wr(8'h07, 8'h6c);
        #1;
        `CHK(lookup_ptr_o, 8'h6c)
        wr(8'h0d, 8'h3c);
        rd(8'h0d, 8'h3c);
        rd(8'hff, 8'h00);
        pulse(6'h04);
        rd(8'h0a, 8'h20);
        wr(8'h0a, 8'hff);
        rd(8'h0a, 8'h2f);
        pulse(6'h01);
        rd(8'h0a, 8'h1f);
        pulse(6'h02);
        rd(8'h0a, 8'h0f);
        wr(8'h0a, 8'h00);
        alu(3'h1, 8'h7f, 8'h01, 8'h0a, 8'h80);
        `CHK(alu_result_o, 8'h80)
        alu(3'h1, 8'hff, 8'h01, 8'h07, 8'h00);
        alu(3'h2, 8'h05, 8'h05, 8'h07, 8'h00);
        alu(3'h2, 8'h00, 8'h01, 8'h00, 8'hff);
        alu(3'h3, 8'h00, 8'h00, 8'h04, 8'h00);
        alu(3'h4, 8'h80, 8'h00, 8'h05, 8'h00);
        alu(3'h5, 8'h00, 8'h00, 8'h04, 8'h80);
        alu(3'h1, 8'hff, 8'h01, 8'h07, 8'h00);
        // Carry in from the flag: add with carry, then subtract with borrow
        @(posedge clk_i);
        alu_use_c_i <= 1'b1;
        alu(3'h1, 8'h01, 8'h01, 8'h00, 8'h03);
        alu(3'h2, 8'h05, 8'h01, 8'h03, 8'h03);
        // Result kept out of the working register
        @(posedge clk_i);
        alu_to_work_i <= 1'b0;
        alu(3'h3, 8'h5c, 8'h00, 8'h03, 8'h03);
        `CHK(alu_result_o, 8'h5c)
        stop_test;
    end
endmodule
